// [verilog/asw_consts.vh]
// constants for the converter sample window control block
// assumes one 200 MHz clock that also serves as the conversion clock
//
// Behaviour
// - window high samples, falling edge starts conversion
// - every conversion lasts exactly 13 clocks
// - window from trigger directly or sample timer
// - two-bit select: software bit or three timer outputs
// - invert setting flips selected trigger polarity
// - first cycle needs rising edge after enable
// - after enable clears, next rising edge starts last
// - pulse mode: soft bit starts; else level samples
// - pulse mode: rising edge starts sample timer
// - slots 0-7 low code, 8-15 high code
// - sample duration is four clocks times count
// - codes 0-11 decode table, 12-15 give 256
// - pulse window spans sync plus sample time
// - pulse mode ignores edges until cycle completes
// - extended mode: trigger drives window, sync delay
// - auto repeat needs timer and nonzero sequence
// - auto repeat off: one edge per cycle
// - auto repeat on: back-to-back until enable clears; list-once mode also stops at sequence end
// - enable behaves the same with auto repeat
// - sequence mode encodes four conversion patterns
`ifndef ASW_CONSTS_VH
`define ASW_CONSTS_VH

// *****************************
// register map, byte addresses
// *****************************
`define ASW_ADDR_W 4
`define ASW_REG_CTRL 4'h0
`define ASW_REG_STATUS 4'h4

// *****************************
// control register fields
// *****************************
`define ASW_CTRL_SOFT_START 0
`define ASW_CTRL_CONV_ENABLE 1
`define ASW_CTRL_PULSE_SEL 2
`define ASW_CTRL_TRIG_INVERT 3
`define ASW_CTRL_TRIG_SRC_LO 4
`define ASW_CTRL_TRIG_SRC_HI 5
`define ASW_CTRL_AUTO_REPEAT 6
`define ASW_CTRL_SEQ_LO 8
`define ASW_CTRL_SEQ_HI 9
`define ASW_CTRL_LOW_TIME_LO 12
`define ASW_CTRL_LOW_TIME_HI 15
`define ASW_CTRL_HIGH_TIME_LO 16
`define ASW_CTRL_HIGH_TIME_HI 19
`define ASW_CTRL_MASK 32'h000F_F37F
`define ASW_CTRL_RESET 32'h0000_0000

// *****************************
// trigger sources and sequence modes
// *****************************
`define ASW_SRC_SOFT 2'h0
`define ASW_SRC_TMR_A1 2'h1
`define ASW_SRC_TMR_B0 2'h2
`define ASW_SRC_TMR_B1 2'h3
`define ASW_SEQ_SINGLE_ONCE 2'h0
`define ASW_SEQ_LIST_ONCE 2'h1
`define ASW_SEQ_SINGLE_REPEAT 2'h2
`define ASW_SEQ_LIST_REPEAT 2'h3

// *****************************
// timing counts in conversion clocks
// *****************************
`define ASW_CONV_CYCLES 11'd13
`define ASW_SAMPLE_MULT 11'd4
`define ASW_SYNC_CYCLES 11'd2
`define ASW_CNT_W 11

`endif

// [verilog/asw_sample_window_control.v]
// sample window control for a 12-bit successive-approximation converter
// assumes trigger inputs synchronous to clk, an Avalon-MM master on the bus,
// and a sequencer that reports the result slot and the end of a sequence
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "asw_consts.vh"

module asw_sample_window_control (
   input wire clk,
   input wire reset_n,
   input wire clkEn,
   input wire [3:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWriteData,
   input wire [3:0] avsByteEnable,
   output reg [31:0] avsReadData,
   output wire avsWaitRequest,
   input wire firstTimerOutputOne,
   input wire secondTimerOutputZero,
   input wire secondTimerOutputOne,
   input wire [3:0] resultSlot,
   input wire sequenceEnd,
   output reg sampleWindow,
   output reg converting,
   output reg conversionDone,
   output reg busy
);

   // *****************************
   // states and decode functions
   // *****************************
   localparam ST_IDLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_EXTEND = 2'h2;
   localparam ST_CONVERT = 2'h3;

   function [`ASW_CNT_W-1:0] decodeTimeCode;
      input [3:0] code;
      begin
         case (code)
            4'h0: decodeTimeCode = 11'd1;
            4'h1: decodeTimeCode = 11'd2;
            4'h2: decodeTimeCode = 11'd4;
            4'h3: decodeTimeCode = 11'd8;
            4'h4: decodeTimeCode = 11'd16;
            4'h5: decodeTimeCode = 11'd24;
            4'h6: decodeTimeCode = 11'd32;
            4'h7: decodeTimeCode = 11'd48;
            4'h8: decodeTimeCode = 11'd64;
            4'h9: decodeTimeCode = 11'd96;
            4'hA: decodeTimeCode = 11'd128;
            4'hB: decodeTimeCode = 11'd192;
            default: decodeTimeCode = 11'd256;
         endcase
      end
   endfunction

   function [31:0] mergeBytes;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0] be;
      integer i;
      begin
         mergeBytes = oldVal;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
            end
         end
      end
   endfunction

   // *****************************
   // reset release
   // *****************************
   reg rstMeta_r;
   reg rstSync_r;
   wire rstN;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end
   assign rstN = rstSync_r;

   // *****************************
   // bus slave
   // *****************************
   reg ack_r;
   reg [31:0] ctrl_r;
   reg [31:0] ctrl_nxt;
   reg [31:0] readData_nxt;
   wire busReq;
   wire busDone;
   wire busWrite;
   wire isCtrl;
   wire isStatus;

   // one wait state: request is answered at the second edge
   assign busReq = avsRead | avsWrite;
   assign busDone = busReq & ack_r & clkEn;
   assign avsWaitRequest = busReq & ~(ack_r & clkEn);
   assign busWrite = avsWrite & busDone;
   assign isCtrl = (avsAddress == `ASW_REG_CTRL);
   assign isStatus = (avsAddress == `ASW_REG_STATUS);

   // *****************************
   // control fields
   // *****************************
   wire softStart = ctrl_r[`ASW_CTRL_SOFT_START];
   wire convEnable = ctrl_r[`ASW_CTRL_CONV_ENABLE];
   wire pulseSel = ctrl_r[`ASW_CTRL_PULSE_SEL];
   wire trigInvert = ctrl_r[`ASW_CTRL_TRIG_INVERT];
   wire [1:0] trigSrc = ctrl_r[`ASW_CTRL_TRIG_SRC_HI:`ASW_CTRL_TRIG_SRC_LO];
   wire autoRepeat = ctrl_r[`ASW_CTRL_AUTO_REPEAT];
   wire [1:0] seqMode = ctrl_r[`ASW_CTRL_SEQ_HI:`ASW_CTRL_SEQ_LO];
   wire [3:0] lowTime = ctrl_r[`ASW_CTRL_LOW_TIME_HI:`ASW_CTRL_LOW_TIME_LO];
   wire [3:0] highTime = ctrl_r[`ASW_CTRL_HIGH_TIME_HI:`ASW_CTRL_HIGH_TIME_LO];

   // *****************************
   // trigger selection and synchroniser
   // *****************************
   reg trigSel;
   reg trigMeta_r;
   reg trigSync_r;
   reg trigPrev_r;
   reg enPrev_r;
   wire trigLevel;
   wire trigRise;
   wire enFall;

   always @* begin
      if (trigSrc == `ASW_SRC_SOFT) begin
         trigSel = softStart;
      end else if (trigSrc == `ASW_SRC_TMR_A1) begin
         trigSel = firstTimerOutputOne;
      end else if (trigSrc == `ASW_SRC_TMR_B0) begin
         trigSel = secondTimerOutputZero;
      end else begin
         trigSel = secondTimerOutputOne;
      end
   end

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         trigMeta_r <= 1'b0;
         trigSync_r <= 1'b0;
         trigPrev_r <= 1'b0;
      end else if (clkEn) begin
         trigMeta_r <= trigSel ^ trigInvert;
         trigSync_r <= trigMeta_r;
         trigPrev_r <= trigSync_r;
      end
   end

   // enable is a register bit already in this domain, so one flop will do
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         enPrev_r <= 1'b0;
      end else if (clkEn) begin
         enPrev_r <= convEnable;
      end
   end

   // a pulse already high when enable rises gives no edge here
   assign trigLevel = trigSync_r;
   assign trigRise = trigSync_r & ~trigPrev_r;
   assign enFall = enPrev_r & ~convEnable;

   // *****************************
   // sample and convert sequencer
   // *****************************
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [`ASW_CNT_W-1:0] cnt_r;
   reg [`ASW_CNT_W-1:0] cnt_nxt;
   reg repeatRun_r;
   reg repeatRun_nxt;
   reg lastPending_r;
   reg lastPending_nxt;
   reg done_nxt;
   wire [`ASW_CNT_W-1:0] sampleLoad;
   wire repeatAllowed;
   wire startOk;
   wire autoCont;

   // sync interval counted into the window so its length is fixed
   assign sampleLoad = `ASW_SYNC_CYCLES +
      `ASW_SAMPLE_MULT * decodeTimeCode(resultSlot[3] ? highTime : lowTime) - 11'd1;
   assign repeatAllowed = autoRepeat & pulseSel & (seqMode != `ASW_SEQ_SINGLE_ONCE);
   assign startOk = trigRise & (convEnable | lastPending_r);
   assign autoCont = repeatRun_r & repeatAllowed & convEnable;

   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      repeatRun_nxt = repeatRun_r;
      lastPending_nxt = lastPending_r;
      done_nxt = 1'b0;
      if (enFall) begin
         lastPending_nxt = 1'b1;
         repeatRun_nxt = 1'b0;
      end else if (convEnable) begin
         lastPending_nxt = 1'b0;
      end
      if (sequenceEnd && seqMode == `ASW_SEQ_LIST_ONCE) begin
         repeatRun_nxt = 1'b0;
      end
      case (state_r)
         ST_IDLE: begin
            // edges are only looked at here, so a running cycle misses them
            if (startOk) begin
               if (!convEnable) begin
                  lastPending_nxt = 1'b0;
               end
               if (pulseSel) begin
                  state_nxt = ST_SAMPLE;
                  cnt_nxt = sampleLoad;
                  repeatRun_nxt = repeatAllowed & convEnable;
               end else begin
                  state_nxt = ST_EXTEND;
               end
            end
         end
         ST_SAMPLE: begin
            if (cnt_r == {`ASW_CNT_W{1'b0}}) begin
               state_nxt = ST_CONVERT;
               cnt_nxt = `ASW_CONV_CYCLES - 11'd1;
            end else begin
               cnt_nxt = cnt_r - 11'd1;
            end
         end
         ST_EXTEND: begin
            if (!trigLevel) begin
               state_nxt = ST_CONVERT;
               cnt_nxt = `ASW_CONV_CYCLES - 11'd1;
            end
         end
         default: begin
            if (cnt_r == {`ASW_CNT_W{1'b0}}) begin
               done_nxt = 1'b1;
               if (autoCont) begin
                  state_nxt = ST_SAMPLE;
                  cnt_nxt = sampleLoad;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end else begin
               cnt_nxt = cnt_r - 11'd1;
            end
         end
      endcase
   end

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_r <= ST_IDLE;
         cnt_r <= {`ASW_CNT_W{1'b0}};
         repeatRun_r <= 1'b0;
         lastPending_r <= 1'b0;
      end else if (clkEn) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         repeatRun_r <= repeatRun_nxt;
         lastPending_r <= lastPending_nxt;
      end
   end

   // *****************************
   // registered outputs
   // *****************************
   // decoded from the next state so outputs line up with the state flops
   wire windowNxt;
   wire convertNxt;
   wire busyNxt;

   assign windowNxt = (state_nxt == ST_SAMPLE) | (state_nxt == ST_EXTEND);
   assign convertNxt = (state_nxt == ST_CONVERT);
   assign busyNxt = (state_nxt != ST_IDLE) | repeatRun_nxt;

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sampleWindow <= 1'b0;
         converting <= 1'b0;
         conversionDone <= 1'b0;
         busy <= 1'b0;
      end else if (clkEn) begin
         sampleWindow <= windowNxt;
         converting <= convertNxt;
         conversionDone <= done_nxt;
         busy <= busyNxt;
      end
   end

   // *****************************
   // status word
   // *****************************
   // read-only snapshot; writes to this offset are dropped
   wire [31:0] statusWord;

   assign statusWord = {26'h0, lastPending_r, repeatRun_r, trigLevel, converting, sampleWindow, busy};

   // *****************************
   // register writes and reads
   // *****************************
   always @* begin
      ctrl_nxt = ctrl_r;
      if (busWrite && isCtrl) begin
         ctrl_nxt = (mergeBytes(ctrl_r, avsWriteData, avsByteEnable) & `ASW_CTRL_MASK);
      end
      // soft start clears itself when a timed cycle ends with no auto repeat following; a write of one wins
      if (pulseSel && done_nxt && !autoCont && ctrl_r[`ASW_CTRL_SOFT_START]) begin
         if (!(busWrite && isCtrl && avsByteEnable[0] && avsWriteData[`ASW_CTRL_SOFT_START])) begin
            ctrl_nxt[`ASW_CTRL_SOFT_START] = 1'b0;
         end
      end
   end

   always @* begin
      if (isCtrl) begin
         readData_nxt = ctrl_r;
      end else if (isStatus) begin
         readData_nxt = statusWord;
      end else begin
         readData_nxt = 32'h0000_0000;
      end
   end

   // the ack flop, stepped by clkEn, paces the bus, one wait state per access while clkEn is high
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ack_r <= 1'b0;
      end else if (clkEn) begin
         ack_r <= busReq & ~ack_r;
      end
   end

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_r <= `ASW_CTRL_RESET;
         avsReadData <= 32'h0000_0000;
      end else if (clkEn) begin
         ctrl_r <= ctrl_nxt;
         if (avsRead && !ack_r) begin
            avsReadData <= readData_nxt;
         end
      end
   end

endmodule

// [tb/asw_timer_model.sv]
// far-side timer outputs that feed the trigger selector
// assumes the bench asks for one pulse at a time
`timescale 1ns/100ps
module asw_timer_model (
   input wire clk,
   input wire go,
   input wire [1:0] sel,
   input wire [11:0] width,
   input wire inv,
   output wire [3:1] tmr
);
   // ***********
   // pulse timer
   // ***********
   reg [11:0] left_r = 12'h000;
   always @(posedge clk) begin
      if (go)
         left_r <= width;
      else if (left_r != 12'h000)
         left_r <= left_r - 12'h001;
   end
   // idle level follows inv, so lines can be parked high
   assign tmr = {3{inv}} ^ ((left_r != 12'h000) ? 3'h1 << (sel - 2'h1) : 3'h0);
endmodule

// [tb/asw_props.sv]
// concurrent checks on the sample window control ports
// assumes clkEn held high, so every clock edge counts
`timescale 1ns/100ps
module asw_props (
   input wire clk,
   input wire reset_n,
   input wire sampleWindow,
   input wire converting,
   input wire conversionDone,
   input wire busy
);
   // ***********
   // conversion run length
   // ***********
   reg [4:0] convCnt_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         convCnt_r <= 5'h00;
      else
         convCnt_r <= converting ? convCnt_r + 5'h01 : 5'h00;
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_convLen;
      $fell(converting) |-> convCnt_r == 5'h0D;
   endproperty
   a_convLen: assert property (p_convLen) else $error("conversion length");
   property p_convStart;
      $fell(sampleWindow) |-> ##[0:1] converting;
   endproperty
   a_convStart: assert property (p_convStart) else $error("no conversion");
   property p_convCause;
      $rose(converting) |-> $past(sampleWindow) || $past(sampleWindow, 2);
   endproperty
   a_convCause: assert property (p_convCause) else $error("conversion without window");
   property p_holdOff;
      converting |-> !sampleWindow;
   endproperty
   a_holdOff: assert property (p_holdOff) else $error("window during conversion");
   property p_doneAfter;
      $fell(converting) |-> conversionDone ##1 !conversionDone;
   endproperty
   a_doneAfter: assert property (p_doneAfter) else $error("done pulse");
   property p_doneCause;
      conversionDone |-> $past(converting) && !converting;
   endproperty
   a_doneCause: assert property (p_doneCause) else $error("stray done");
   property p_busy;
      sampleWindow || converting |-> busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low");
   property p_winRise;
      $rose(sampleWindow) |-> !$past(converting) || conversionDone;
   endproperty
   a_winRise: assert property (p_winRise) else $error("window overlaps");
   c_done: cover property ($fell(converting));
   c_backToBack: cover property ($rose(sampleWindow) && conversionDone);
   c_busyConv: cover property (converting && busy);
endmodule

// [tb/test_asw_sample_window_control.sv]
// self-checking bench for the sample window control
// assumes all byte lanes enabled and clkEn held high
`timescale 1ns/100ps
module test_asw_sample_window_control;
   reg clk = 1'b0, reset_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, go = 1'b0, inv = 1'b1, seqEnd = 1'b0;
   reg [1:0] sel = 2'h1;
   reg [3:0] addr = 4'h0, slot = 4'h0;
   reg [11:0] width = 12'h000;
   reg [31:0] wdata = 32'h0000_0000, rd;
   wire [31:0] rdata;
   wire waitReq, win, conv, done;
   wire [3:1] tmr;
   integer n_errors = 0, total_checks = 0, cyc = 0, nd, w, c, k;
   asw_sample_window_control DUT (.clk(clk), .reset_n(reset_n), .clkEn(1'b1), .avsAddress(addr),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(wdata), .avsByteEnable(4'hF),
      .avsReadData(rdata), .avsWaitRequest(waitReq), .firstTimerOutputOne(tmr[1]),
      .secondTimerOutputZero(tmr[2]), .secondTimerOutputOne(tmr[3]), .resultSlot(slot),
      .sequenceEnd(seqEnd), .sampleWindow(win), .converting(conv), .conversionDone(done), .busy());
   asw_timer_model far (.clk(clk), .go(go), .sel(sel), .width(width), .inv(inv), .tmr(tmr));
   always #2.5 clk = ~clk;
   // ***********
   // helpers
   // ***********
   task close_out;
      begin
         if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input ok, input integer id);
      begin
         total_checks = total_checks + 1;
         if (ok !== 1'b1) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t check %0d failed", $time, id);
         end
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         chk(1'b0, 0);
         close_out;
      end
   end
   // holds the request until waitrequest is seen low at an edge
   task bus(input isWr, input [3:0] a, input [31:0] d);
      begin
         addr <= a;
         wdata <= d;
         avsWrite <= isWr;
         avsRead <= !isWr;
         @(posedge clk);
         while (waitReq !== 1'b0)
            @(posedge clk);
         rd = rdata;
         avsWrite <= 1'b0;
         avsRead <= 1'b0;
         @(posedge clk);
      end
   endtask
   task wr(input [31:0] d);
      bus(1'b1, 4'h0, d);
   endtask
   function [31:0] cw(input [7:0] hl, input [1:0] sq, input rp, input [1:0] s, input [3:0] f);
      cw = {12'h000, hl, 2'h0, sq, 1'b0, rp, s, f};
   endfunction
   function integer nOf(input [3:0] q);
      if (q > 4'hB)
         nOf = 256;
      else if (q < 4'h4)
         nOf = 1 << q;
      else
         nOf = (q[0] ? 24 : 16) << ((q - 4'h4) >> 1);
   endfunction
   task trig(input [1:0] s, input [11:0] wd);
      begin
         sel <= s;
         width <= wd;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
      end
   endtask
   task cnt(input integer m);
      for (nd = 0; m > 0; m = m - 1) begin
         @(posedge clk);
         if (done === 1'b1)
            nd = nd + 1;
      end
   endtask
   task meas;
      begin
         for (w = 0; win !== 1'b1 && w < 40; w = w + 1)
            @(posedge clk);
         for (w = 0; win === 1'b1 && w < 1100; w = w + 1)
            @(posedge clk);
         if (conv !== 1'b1)
            @(posedge clk);
         for (c = 0; conv === 1'b1 && c < 20; c = c + 1)
            @(posedge clk);
         chk(c == 13 && done === 1'b1, 1);
      end
   endtask
   // ***********
   // scenarios
   // ***********
   task pulseRun(input [3:0] q, input hb, input [1:0] s, input iv);
      begin
         slot <= {hb, 3'h5};
         wr(cw(hb ? {q, ~q} : {~q, q}, 2'h0, 1'b0, s, {iv, 2'h3, s == 2'h0}));
         if (s != 2'h0)
            trig(s, 12'h004);
         meas;
         chk(w == 2 + 4 * nOf(q), 2);
      end
   endtask
   task tRegs;
      begin
         wr(32'hFFFF_FFF4);
         bus(1'b0, 4'h0, 32'h0);
         chk(rd === 32'h000F_F374, 3);
         bus(1'b1, 4'h8, 32'hFFFF_FFFF);
         bus(1'b0, 4'h8, 32'h0);
         chk(rd === 32'h0000_0000, 4);
         wr(32'h0);
      end
   endtask
   // lines parked high, so the inverted select sees a rising edge as each line falls
   task tInvLast;
      begin
         pulseRun(4'h0, 1'b0, 2'h1, 1'b1);
         wr(cw(8'h00, 2'h0, 1'b0, 2'h1, 4'hC));
         inv <= 1'b0;
         cnt(80);
         chk(nd == 1, 5);
         trig(2'h1, 12'h004);
         cnt(80);
         chk(nd == 0, 6);
         wr(32'h0);
      end
   endtask
   task tTimes;
      for (k = 0; k < 16; k = k + 1)
         pulseRun(k[3:0], k[0], k[1:0], 1'b0);
   endtask
   task tIgnore;
      begin
         wr(cw(8'h33, 2'h0, 1'b0, 2'h1, 4'h6));
         trig(2'h1, 12'h004);
         repeat (12) @(posedge clk);
         trig(2'h1, 12'h004);
         cnt(100);
         chk(nd == 1, 7);
      end
   endtask
   task tEnable;
      begin
         wr(cw(8'h00, 2'h0, 1'b0, 2'h1, 4'h4));
         trig(2'h1, 12'h004);
         cnt(60);
         chk(nd == 1, 8);
         trig(2'h1, 12'h0C8);
         repeat (8) @(posedge clk);
         wr(cw(8'h00, 2'h0, 1'b0, 2'h1, 4'h6));
         cnt(260);
         chk(nd == 0, 9);
         trig(2'h1, 12'h004);
         cnt(60);
         chk(nd == 1, 10);
      end
   endtask
   task autoRun(input rp, input [1:0] sq, input many);
      begin
         wr(cw(8'h00, sq, rp, 2'h1, 4'h6));
         trig(2'h1, 12'h004);
         cnt(120);
         chk(nd > 0 && (nd > 2) == many, 11);
         wr(cw(8'h00, sq, rp, 2'h1, 4'h4));
         cnt(60);
         cnt(60);
         chk(nd == 0, 12);
      end
   endtask
   task tExt;
      begin
         wr(cw(8'h00, 2'h0, 1'b0, 2'h1, 4'h2));
         trig(2'h1, 12'h014);
         meas;
         chk(w >= 19 && w <= 21, 13);
         wr(cw(8'h00, 2'h0, 1'b0, 2'h0, 4'h3));
         repeat (20) @(posedge clk);
         wr(cw(8'h00, 2'h0, 1'b0, 2'h0, 4'h2));
         cnt(40);
         chk(nd == 1, 14);
      end
   endtask
   // list-once mode with auto repeat stops once the sequencer flags the end
   task tSeqEnd;
      begin
         wr(cw(8'h00, 2'h1, 1'b1, 2'h1, 4'h6));
         trig(2'h1, 12'h004);
         cnt(60);
         chk(nd >= 2, 15);
         seqEnd <= 1'b1;
         @(posedge clk);
         seqEnd <= 1'b0;
         cnt(40);
         cnt(60);
         chk(nd == 0, 16);
         wr(32'h0);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      tRegs;
      tInvLast;
      tTimes;
      tIgnore;
      tEnable;
      autoRun(1'b1, 2'h0, 1'b0);
      autoRun(1'b0, 2'h2, 1'b0);
      autoRun(1'b1, 2'h2, 1'b1);
      autoRun(1'b1, 2'h3, 1'b1);
      tSeqEnd;
      tExt;
      close_out;
   end
endmodule
bind asw_sample_window_control asw_props u_props (.clk(clk), .reset_n(reset_n), .sampleWindow(sampleWindow),
   .converting(converting), .conversionDone(conversionDone), .busy(busy));
